// *** hw/dimming_defs.svh ***
// constants for dimming mode selection and pwm reference gating
// assumes a 25 MHz block clock; counts derive from the times below
`ifndef DIMMING_DEFS_SVH
`define DIMMING_DEFS_SVH

// clock period of ref_clk
`define CLK_PERIOD_NS               40

// detection delay after the enabling edge (least time, round up)
`define ONEWIRE_DETECT_DELAY_NS     100000
`define ONEWIRE_DETECT_DELAY_CYC    ((`ONEWIRE_DETECT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// low time the host must exceed (least time, round up)
`define ONEWIRE_LOW_DETECT_TIME_NS  260000
`define ONEWIRE_LOW_DETECT_CYC      ((`ONEWIRE_LOW_DETECT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// detection window from the enabling edge (longest time, round down)
`define ONEWIRE_DETECT_WINDOW_NS    1000000
`define ONEWIRE_DETECT_WINDOW_CYC   (`ONEWIRE_DETECT_WINDOW_NS / `CLK_PERIOD_NS)

// low time that shuts the device down (least time, round up)
`define SHUTDOWN_LOW_TIME_NS        2500000
`define SHUTDOWN_LOW_CYC            ((`SHUTDOWN_LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// full-scale feedback reference in millivolts
`define FULL_SCALE_MV               8'hc8
`define REF_W                       8
`define CNT_W                       17

// low-pass filter: fraction bits and shift of the first-order step
`define LPF_FRAC                    8
`define LPF_SHIFT                   8

`endif

// *** hw/dimming_pkg.sv ***
// types shared by the dimming mode selector and its reference filter
// assumes dimming_defs.svh sits on the include path
`include "dimming_defs.svh"

package dimming_pkg;

    typedef enum logic { MODE_PWM, MODE_ONEWIRE } dim_mode_t;

    typedef enum logic [1:0] { ST_OFF, ST_DETECT, ST_RUN } ctrl_state_t;

    typedef logic [`CNT_W-1:0] cnt_t;
    typedef logic [`REF_W-1:0] mv_t;

endpackage

// *** hw/ref_filter_if.sv ***
// carrier between the mode selector and the reference low-pass filter
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface ref_filter_if;
    import dimming_pkg::*;

    mv_t target; // gated reference, millivolts
    mv_t level;  // smoothed reference, millivolts

    modport src  (output target, input level);
    modport filt (input target, output level);
endinterface

`default_nettype wire

// *** hw/ref_lpf.sv ***
// first-order low-pass filter that smooths the gated reference
// assumes target changes on ref_clk; output comes from a register
`timescale 1ns/100ps
`default_nettype none
`include "dimming_defs.svh"

module ref_lpf #(
    parameter int SHIFT = `LPF_SHIFT
) (
    input  wire logic   ref_clk,
    input  wire logic   rst,
    ref_filter_if.filt  f
);
    import dimming_pkg::*;

    localparam int AW = `REF_W + `LPF_FRAC;

    typedef struct packed {
        logic [AW-1:0] acc;
    } lpf_state_t;

    lpf_state_t          s_q;
    lpf_state_t          s_d;
    logic signed [AW+1:0] diff;
    logic signed [AW+1:0] step;

    // move the accumulator a fraction of the way toward the target
    always_comb
    begin
        s_d  = s_q;
        diff = $signed({2'b00, f.target, `LPF_FRAC'(0)}) - $signed({2'b00, s_q.acc});
        // round away from zero so the level settles exactly on target
        if (diff > 0)
            step = (diff + $signed((AW+2)'((1 << SHIFT) - 1))) >>> SHIFT;
        else
            step = diff >>> SHIFT;
        s_d.acc = s_q.acc + step[AW-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign f.level = s_q.acc[AW-1 -: `REF_W];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // a full-scale step is never passed through in one cycle
    property p_lpf_smooth;
        f.target == `FULL_SCALE_MV && f.level == '0 |=> f.level < `FULL_SCALE_MV;
    endproperty
    a_lpf_smooth: assert property (p_lpf_smooth) else $error("filter passed a step unsmoothed");

endmodule // ref_lpf

`default_nettype wire

// *** hw/dimming_mode_select_pwm_ref.sv ***
// dimming mode selection from the control pin and pwm reference gating
// assumes ctrl_pin is asynchronous; onewire_ref_mv comes from the
// one-wire command decoder on ref_clk; rst is the power-on reset
//
// Function
// - the device runs in pwm dimming unless one-wire entry is seen during start-up.
// - the dimming mode is picked again on every start from shutdown from the pin waveform.
// - a rising edge on the control pin enables the device and starts one-wire detection.
// - one-wire entry needs the pin low longer than 260 us after a 100 us delay from enable.
// - that low period must complete before the 1 ms detection window closes.
// - the detection window is timed from the first rising edge after shutdown.
// - once all three conditions hold, one-wire mode is entered with no further wait.
// - one-wire commands are accepted right after entry, even inside the window.
// - the selected mode stays locked until shutdown and a fresh start.
// - holding the pin low for 2.5 ms shuts the device down; raising it restarts.
// - in pwm mode a pin held high yields the full-scale 200 mV reference.
// - in pwm mode the reference is gated by the pin, averaging to duty times 200 mV.
// - the gated reference is low-pass filtered so the led current stays dc.
`timescale 1ns/100ps
`default_nettype none
`include "dimming_defs.svh"

module dimming_mode_select_pwm_ref #(
    parameter int LOW_DETECT_CYC = `ONEWIRE_LOW_DETECT_CYC,
    parameter int WINDOW_CYC     = `ONEWIRE_DETECT_WINDOW_CYC,
    parameter int SHUTDOWN_CYC   = `SHUTDOWN_LOW_CYC,
    parameter int LPF_SHIFT      = `LPF_SHIFT
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ctrl_pin,
    input  wire dimming_pkg::mv_t  onewire_ref_mv,
    output logic                   device_enable,
    output dimming_pkg::dim_mode_t dimming_mode,
    output logic                   onewire_active,
    output logic                   onewire_entered,
    output dimming_pkg::mv_t       feedback_reference
);
    import dimming_pkg::*;

    localparam int DELAY_CYC = `ONEWIRE_DETECT_DELAY_CYC;

    typedef struct packed {
        logic        sync1;    // first synchroniser stage
        logic        sync2;    // second synchroniser stage
        logic        prev;     // pin one cycle later, for edges
        ctrl_state_t st;
        dim_mode_t   mode;
        logic        en;
        logic        ow_act;
        logic        ow_pulse;
        cnt_t        win;      // cycles since the enabling edge
        cnt_t        lo;       // consecutive low cycles
        cnt_t        det;      // low cycles counted after the delay
        mv_t         tgt;      // gated reference to the filter
    } sel_state_t;

    sel_state_t   s_q;
    sel_state_t   s_d;
    logic         rise;
    logic         det_hit;
    logic         win_end;
    logic         shut;
    ref_filter_if rf ();

    // saturating increment keeps long lows from wrapping
    function automatic cnt_t inc_sat(input cnt_t c);
        inc_sat = (c == '1) ? c : c + cnt_t'(1);
    endfunction

    // next-state logic for synchroniser, mode selection and gating
    always_comb
    begin
        s_d          = s_q;
        s_d.sync1    = ctrl_pin;
        s_d.sync2    = s_q.sync1;
        s_d.prev     = s_q.sync2;
        s_d.ow_pulse = 1'b0;
        rise         = s_q.sync2 & ~s_q.prev;
        det_hit      = 1'b0;
        win_end      = 1'b0;
        shut         = 1'b0;

        // low-time counter used for shutdown
        s_d.lo = s_q.sync2 ? '0 : inc_sat(s_q.lo);

        unique case (s_q.st)
            ST_OFF:
            begin
                s_d.en     = 1'b0;
                s_d.ow_act = 1'b0;
                if (rise)
                begin
                    // enable and start the window on this edge
                    s_d.st   = ST_DETECT;
                    s_d.en   = 1'b1;
                    s_d.mode = MODE_PWM;
                    s_d.win  = '0;
                    s_d.det  = '0;
                end
            end
            ST_DETECT:
            begin
                s_d.win = inc_sat(s_q.win);
                // only lows after the delay count toward entry
                if (s_q.win >= cnt_t'(DELAY_CYC) && !s_q.sync2)
                    s_d.det = inc_sat(s_q.det);
                else
                    s_d.det = '0;
                det_hit = s_d.det > cnt_t'(LOW_DETECT_CYC);
                win_end = s_d.win >= cnt_t'(WINDOW_CYC);
                if (det_hit)
                begin
                    // enter one-wire at once, window still open
                    s_d.st       = ST_RUN;
                    s_d.mode     = MODE_ONEWIRE;
                    s_d.ow_act   = 1'b1;
                    s_d.ow_pulse = 1'b1;
                end
                else if (win_end)
                begin
                    s_d.st   = ST_RUN;
                    s_d.mode = MODE_PWM;
                end
            end
            ST_RUN:
            begin
                // mode held; nothing to do until shutdown
                s_d.mode = s_q.mode;
            end
        endcase

        // a long low shuts down from any enabled state
        if (s_q.st != ST_OFF && s_d.lo > cnt_t'(SHUTDOWN_CYC))
        begin
            shut       = 1'b1;
            s_d.st     = ST_OFF;
            s_d.en     = 1'b0;
            s_d.mode   = MODE_PWM;
            s_d.ow_act = 1'b0;
            s_d.ow_pulse = 1'b0;
        end

        // gate the reference with the pin in pwm mode
        if (s_d.st == ST_OFF)
            s_d.tgt = '0;
        else if (s_d.mode == MODE_ONEWIRE)
            s_d.tgt = onewire_ref_mv;
        else if (s_q.sync2)
            s_d.tgt = `FULL_SCALE_MV;
        else
            s_d.tgt = '0;
    end

    // state register, power-on reset to the off state
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_q      <= '0;
            s_q.st   <= ST_OFF;
            s_q.mode <= MODE_PWM;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // smoothing filter for the gated reference
    assign rf.target = s_q.tgt;

    ref_lpf #(
        .SHIFT (LPF_SHIFT)
    ) u_lpf (
        .ref_clk (ref_clk),
        .rst     (rst),
        .f       (rf.filt)
    );

    // outputs straight from registers
    assign device_enable      = s_q.en;
    assign dimming_mode       = s_q.mode;
    assign onewire_active     = s_q.ow_act;
    assign onewire_entered    = s_q.ow_pulse;
    assign feedback_reference = rf.level;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // rising edge in shutdown enables and restarts the window
    property p_enable_on_rise;
        s_q.st == ST_OFF && rise |=> s_q.en && s_q.st == ST_DETECT && s_q.win == '0;
    endproperty
    a_enable_on_rise: assert property (p_enable_on_rise) else $error("rising edge did not enable");

    // every fresh start begins in pwm mode
    property p_start_pwm;
        $rose(s_q.en) |-> s_q.mode == MODE_PWM && !s_q.ow_act;
    endproperty
    a_start_pwm: assert property (p_start_pwm) else $error("start did not default to pwm");

    // window timed from the edge: counts one per cycle while detecting
    property p_window_count;
        s_q.st == ST_DETECT ##1 s_q.st == ST_DETECT |-> s_q.win == $past(s_q.win) + cnt_t'(1);
    endproperty
    a_window_count: assert property (p_window_count) else $error("window counter slipped");

    // qualifying low switches mode on the very next edge
    property p_enter_now;
        s_q.st == ST_DETECT && det_hit && !shut |=> s_q.mode == MODE_ONEWIRE && s_q.ow_pulse && s_q.ow_act;
    endproperty
    a_enter_now: assert property (p_enter_now) else $error("one-wire entry delayed");

    // entry only after delay plus low time have elapsed
    property p_entry_late_enough;
        $rose(s_q.ow_pulse) |-> s_q.win > cnt_t'(DELAY_CYC + LOW_DETECT_CYC);
    endproperty
    a_entry_late_enough: assert property (p_entry_late_enough) else $error("one-wire entered too early");

    // window closing without a qualifying low leaves pwm
    property p_window_close_pwm;
        s_q.st == ST_DETECT && win_end && !det_hit && !shut |=> s_q.st == ST_RUN && s_q.mode == MODE_PWM;
    endproperty
    a_window_close_pwm: assert property (p_window_close_pwm) else $error("window close left wrong mode");

    // no one-wire entry once the window has run out
    property p_no_late_entry;
        $rose(s_q.ow_pulse) |-> s_q.win <= cnt_t'(WINDOW_CYC);
    endproperty
    a_no_late_entry: assert property (p_no_late_entry) else $error("entry after window close");

    // mode locked while running
    property p_mode_locked;
        s_q.st == ST_RUN ##1 s_q.st == ST_RUN |-> $stable(s_q.mode);
    endproperty
    a_mode_locked: assert property (p_mode_locked) else $error("mode changed while running");

    // one-wire commands accepted from the entry cycle on
    property p_accept_now;
        s_q.ow_pulse |-> s_q.ow_act && s_q.en;
    endproperty
    a_accept_now: assert property (p_accept_now) else $error("one-wire not active on entry");

    // long low shuts the device down on the next edge
    property p_shutdown;
        s_q.st != ST_OFF && shut |=> !s_q.en && s_q.st == ST_OFF;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("long low did not shut down");

    // pin high in pwm run gates full scale into the filter
    property p_pwm_high_full;
        s_q.st == ST_RUN && s_q.mode == MODE_PWM && s_q.sync2 && !shut ##1 s_q.st == ST_RUN
            |-> s_q.tgt == `FULL_SCALE_MV;
    endproperty
    a_pwm_high_full: assert property (p_pwm_high_full) else $error("pwm high not full scale");

    // pin low in pwm mode gates the reference off
    property p_pwm_low_zero;
        s_q.en && s_q.mode == MODE_PWM && !s_q.sync2 && !det_hit |=> s_q.tgt == '0;
    endproperty
    a_pwm_low_zero: assert property (p_pwm_low_zero) else $error("pwm low not gated off");

    // held high in pwm, the reference never falls
    property p_pwm_rising_ref;
        (s_q.st == ST_RUN && s_q.mode == MODE_PWM && s_q.tgt == `FULL_SCALE_MV) [*4]
            |-> feedback_reference >= $past(feedback_reference, 3);
    endproperty
    a_pwm_rising_ref: assert property (p_pwm_rising_ref) else $error("reference fell while high");

endmodule // dimming_mode_select_pwm_ref

`default_nettype wire

// *** verification/host_ctrl_model.sv ***
// host side model: drives the control pin level by level
// assumes the bench calls its tasks; the pin is always driven, never released
`timescale 1ns/100ps
`default_nettype none

module host_ctrl_model (
    input  wire logic ref_clk,
    output logic      ctrl_pin
);
    initial ctrl_pin = 1'b0;

    // hold one level for n cycles, changed just after an edge
    task automatic drive(input logic lvl, input int n);
        @(posedge ref_clk);
        #2 ctrl_pin = lvl; // rising level enables
        repeat (n - 1) @(posedge ref_clk);
    endtask

    // low phase of 2100 cycles exceeds the shortened shutdown count
    task automatic shut_down();
        drive(1'b0, 2100);
    endtask

    // pwm at 250-cycle period (100 kHz), low phase far below shutdown
    task automatic pwm(input int high, input int periods);
        repeat (periods)
        begin
            drive(1'b1, high);
            drive(1'b0, 250 - high);
        end
    endtask
endmodule // host_ctrl_model

`default_nettype wire

// *** verification/dimming_mode_select_pwm_ref_tb_top.sv ***
// bench: integer model of mode selection and reference, compared at results
// assumes host_ctrl_model drives ctrl_pin; counts shortened by parameters
`timescale 1ns/100ps
`default_nettype none

module dimming_mode_select_pwm_ref_tb_top;
    import dimming_pkg::*;
    localparam int LOW = 20;
    localparam int WIN = 2600;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    wire logic ctrl_pin;
    mv_t  ow_mv = 8'h00;
    logic en, act, ent;
    dim_mode_t mode;
    mv_t  fb;
    int   err_total = 0, samples_checked = 0, cyc = 0, pulse_cnt = 0, ent_cyc = 0;

    always #20 ref_clk = ~ref_clk;

    host_ctrl_model host (.ref_clk(ref_clk), .ctrl_pin(ctrl_pin));

    dimming_mode_select_pwm_ref #(.LOW_DETECT_CYC(LOW), .WINDOW_CYC(WIN), .SHUTDOWN_CYC(2000), .LPF_SHIFT(2)) uut (
        .ref_clk(ref_clk), .rst(rst), .ctrl_pin(ctrl_pin), .onewire_ref_mv(ow_mv),
        .device_enable(en), .dimming_mode(mode), .onewire_active(act),
        .onewire_entered(ent), .feedback_reference(fb));

    // cycle count and entry pulse capture
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (ent === 1'b1)
        begin
            pulse_cnt++;
            ent_cyc = cyc;
        end
    end

    task automatic chk1(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk8(input string nm, input mv_t e, input mv_t g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic chk_near(input string nm, input int e, input int g, input int tol);
        samples_checked++;
        if (g < e - tol || g > e + tol)
        begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // model: low must start after the delay, outlast the low count, reach that count inside the window
    function automatic bit model_onewire(input int start, input int len);
        return start >= 2505 && len > LOW + 5 && start + LOW + 5 < WIN;
    endfunction

    // one start-up with a low pulse after start cycles, then shutdown
    task automatic run_trial(input int start, input int len);
        int p0, low_cyc;
        bit e;
        p0 = pulse_cnt;
        e = model_onewire(start, len);
        host.drive(1'b1, start);
        low_cyc = cyc;
        host.drive(1'b0, len);
        host.drive(1'b1, (2800 - start - len > 150) ? 2800 - start - len : 150);
        chk1("enable", 1'b1, en);
        chk1("mode", e, logic'(mode));
        chk1("active", e, act);
        chk_near("pulses", e ? 1 : 0, pulse_cnt - p0, 0);
        if (e)
        begin
            chk_near("entry latency", LOW + 3, ent_cyc - low_cyc, 4);
            @(posedge ref_clk);
            #2 ow_mv = mv_t'($urandom_range(200));
            repeat (60) @(posedge ref_clk);
            chk8("fb onewire", ow_mv, fb);
            host.pwm(60, 3);
            chk1("mode locked", 1'b1, logic'(mode));
        end
        else
            chk8("fb high", 8'hc8, fb);
        host.shut_down();
        chk1("enable off", 1'b0, en);
        chk1("mode off", 1'b0, logic'(mode));
        chk1("active off", 1'b0, act);
        $display("test trial start %0d len %0d done", start, len);
    endtask

    // pwm duty check: average reference over whole periods
    task automatic run_pwm(input int high);
        int sum;
        sum = 0;
        fork
            host.pwm(high, 6);
            begin
                repeat (500) @(posedge ref_clk);
                repeat (1000)
                begin
                    @(posedge ref_clk);
                    #1 sum += int'(fb);
                end
            end
        join
        chk_near("fb average", high * 200 / 250, sum / 1000, 6);
        chk1("mode pwm", 1'b0, logic'(mode));
        $display("test pwm high %0d done", high);
    endtask

    // watchdog: planned run is about 70000 cycles
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        $display("BAD watchdog expected finish seen hang");
        tally_and_finish();
    end

    // fixed trials: entry, early low, short low, late low, entry
    int tbl_s[5] = '{2520, 1000, 2520, 2590, 2560};
    int tbl_l[5] = '{40, 40, 10, 40, 60};

    // main sequence
    initial
    begin
        void'($urandom(59));
        repeat (20) @(posedge ref_clk);
        #2 rst = 1'b0;
        @(posedge ref_clk);
        #2;
        chk1("reset enable", 1'b0, en);
        chk1("reset mode", 1'b0, logic'(mode));
        chk8("reset fb", 8'h00, fb);
        $display("test reset done");
        foreach (tbl_s[i])
            run_trial(tbl_s[i], tbl_l[i]);
        repeat (6)
        begin
            case ($urandom_range(2))
                0: run_trial($urandom_range(2400, 1000), $urandom_range(60, 30));
                1: run_trial($urandom_range(2560, 2510), $urandom_range(60, 30));
                default: run_trial($urandom_range(2560, 2510), $urandom_range(15, 5));
            endcase
        end
        host.drive(1'b1, 2800);
        run_pwm(50);
        run_pwm(125);
        run_pwm(200);
        host.shut_down();
        tally_and_finish();
    end
endmodule // dimming_mode_select_pwm_ref_tb_top

`default_nettype wire
